/* core/uad_pkg.sv */
package uad_pkg;
    // Register indices on the local register port.
    localparam logic [2:0] ADDR_RX_DATA = 3'h0;
    localparam logic [2:0] ADDR_RX_STAT = 3'h1;
    localparam logic [2:0] ADDR_TX_STAT = 3'h2;
    localparam logic [2:0] ADDR_BAUD = 3'h3;
    localparam logic [2:0] ADDR_IRQ_EN = 3'h4;
    localparam logic [2:0] ADDR_IRQ_FLAG = 3'h5;
    // Receive status and control fields.
    localparam int RS_PORT_EN = 7;
    localparam int RS_RX9 = 6;
    localparam int RS_SINGLE_RECEIVE_ENABLE = 5;
    localparam int RS_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int RS_ADDRESS_DETECT_ENABLE = 3;
    localparam int RS_FRAMING_ERROR_FLAG = 2;
    localparam int RS_OVERRUN_ERROR_FLAG = 1;
    localparam int RS_RX_NINTH_DATA_BIT = 0;
    // Transmit status and control fields.
    localparam int TS_CLOCK_SOURCE_SELECT = 7;
    localparam int TS_TX9 = 6;
    localparam int TS_TRANSMIT_ENABLE = 5;
    localparam int TS_SYNC = 4;
    localparam int TS_HIGH_SPEED_BAUD_SELECT = 2;
    localparam int TS_TX_SHIFT_EMPTY = 1;
    localparam int TS_TX_NINTH_DATA_BIT = 0;
    // Interrupt enable and flag position for the receive character.
    localparam int IRQ_RX_BIT = 5;
    // Writable masks and reset values.
    localparam logic [7:0] RS_WMASK = 8'hf8;
    localparam logic [7:0] TS_WMASK = 8'hf5;
    localparam logic [7:0] RS_RST = 8'h00;
    localparam logic [7:0] TS_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [7:0] IRQ_EN_RST = 8'h00;
    // Baud generator ticks per bit for each mode.
    localparam logic [6:0] MULT_LOW = 7'h40;
    localparam logic [6:0] MULT_HIGH = 7'h10;
    localparam logic [6:0] MULT_SYNC = 7'h04;
    // Receive buffer depth in characters.
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    // One received character with its own status.
    typedef struct packed {
        logic framing_error_flag;
        logic nine;
        logic [7:0] data;
    } uad_char_t;

    // One register port request.
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } uad_bus_t;

    // Controls handed to the transmitter datapath.
    typedef struct packed {
        logic enable;
        logic nine;
        logic ninth;
        logic master_clk;
    } uad_tx_ctl_t;

    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} uad_rx_state_t;
endpackage

/* core/uad_top.sv */
// What this block does
// - Address detect keeps only ninth-bit-set characters.
// - Address character into buffer raises receive flag.
// - Buffered ninth bit reads one under detect.
// - Overrun flag read-only, cleared with receive enable.
// - Framing flag follows top buffered character.
// - Port enable claims pins; clear holds reset.
// - Nine-bit select; detect ignored in eight-bit.
// - Single receive one shot, hardware cleared.
// - Continuous receive enables, beats single receive.
// - Ninth bit shown raw, no parity.
// - Clock source picks master or slave.
// - Nine-bit transmit with supplied ninth bit.
// - Receive enables override transmit in sync.
// - Mode select; transmit bit 3 reads zero.
// - High speed select only in async.
// - Shift empty status read-only, resets one.
// - Free-running 8-bit shared baud timer.
// - Divisor write restarts the baud timer.
// - Bit time is 64, 16 or 4 ticks.
// - Two-deep buffer; third character sets overrun.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uad_top
    import uad_pkg::*;
(
    input wire logic clk_i, // System clock, 200 MHz.
    input wire logic resetn_i, // Asynchronous reset, active low.
    input wire uad_bus_t bus_i, // Register port request.
    output logic [7:0] rd_data_o, // Read data, cycle after read.
    input wire logic rx_i, // Receive pin, asynchronous.
    input wire logic tx_shift_full_i, // Transmit shift register holds data.
    input wire logic sync_rx_done_i, // Synchronous reception finished.
    output logic rx_flag_o, // Unread character present.
    output logic rx_irq_en_o, // Receive interrupt enable bit.
    output uad_tx_ctl_t tx_ctl_o, // Transmitter controls.
    output logic pin_serial_o, // Pins belong to the serial port.
    output logic sync_rx_en_o, // Synchronous receive requested.
    output logic baud_tick_o // One pulse per bit time.
);
    // Control registers and their decoded fields.
    logic [7:0] rs_ctl_ff; // Receive control bits.
    logic [7:0] ts_ctl_ff; // Transmit control bits.
    logic [7:0] baud_ff; // Baud divisor.
    logic [7:0] irq_en_ff; // Peripheral interrupt enables.
    logic tx_empty_ff; // Transmit shift empty status.
    logic port_enable, rx9, single_receive_enable, continuous_receive_enable, address_detect_enable;
    logic sync_mode, high_speed_baud_select, master;
    assign port_enable = rs_ctl_ff[RS_PORT_EN];
    assign rx9 = rs_ctl_ff[RS_RX9];
    assign single_receive_enable = rs_ctl_ff[RS_SINGLE_RECEIVE_ENABLE];
    assign continuous_receive_enable = rs_ctl_ff[RS_CONTINUOUS_RECEIVE_ENABLE];
    assign address_detect_enable = rs_ctl_ff[RS_ADDRESS_DETECT_ENABLE];
    assign sync_mode = ts_ctl_ff[TS_SYNC];
    assign high_speed_baud_select = ts_ctl_ff[TS_HIGH_SPEED_BAUD_SELECT];
    assign master = ts_ctl_ff[TS_CLOCK_SOURCE_SELECT];

    // Decoded strobes.
    logic wr_rs, wr_ts, wr_baud, wr_irq, rd_rxd;
    assign wr_rs = bus_i.we && bus_i.addr == ADDR_RX_STAT;
    assign wr_ts = bus_i.we && bus_i.addr == ADDR_TX_STAT;
    assign wr_baud = bus_i.we && bus_i.addr == ADDR_BAUD;
    assign wr_irq = bus_i.we && bus_i.addr == ADDR_IRQ_EN;
    assign rd_rxd = bus_i.re && bus_i.addr == ADDR_RX_DATA;

    // Receiver state and buffer.
    uad_rx_state_t state_ff;
    logic [6:0] ph_ff; // Baud ticks inside current bit.
    logic [3:0] bit_ff; // Data bits taken so far.
    logic [8:0] sh_ff; // Receive shift register.
    uad_char_t mem_ff [0:1]; // Two-entry receive buffer.
    logic [1:0] count_ff; // Characters held.
    logic overrun_error_flag_ff; // Overrun flag.
    logic [7:0] brg_ff; // Baud timer.
    logic [6:0] pre_ff; // Ticks toward one bit time.
    logic s1_ff, s2_ff, prev_ff; // Pin synchroniser and history.

    // Mode decode for the receiver and baud generator.
    logic rx_en, addr_mode, brg_tick;
    logic [6:0] mult;
    assign rx_en = port_enable && continuous_receive_enable && !sync_mode;
    assign addr_mode = rx9 && address_detect_enable;
    assign brg_tick = brg_ff == baud_ff;
    always_comb begin
        // HIGH_SPEED_BAUD_SELECT is ignored once the port runs synchronous.
        if (sync_mode) begin
            mult = MULT_SYNC;
        end else if (high_speed_baud_select) begin
            mult = MULT_HIGH;
        end else begin
            mult = MULT_LOW;
        end
    end

    // Receive completion and buffer control.
    logic rx_done, rx_keep, push, pop, full;
    logic [1:0] wi;
    uad_char_t rx_char;
    // Gated by the enable so a frame cut by disabling never lands or flags overrun.
    assign rx_done = rx_en && state_ff == RX_STOP && brg_tick && ph_ff == mult - 7'h01;
    always_comb begin
        rx_char.framing_error_flag = !s2_ff;
        rx_char.nine = rx9 ? sh_ff[8] : 1'b0;
        rx_char.data = rx9 ? sh_ff[7:0] : sh_ff[8:1];
    end
    assign rx_keep = rx_done && !(addr_mode && !rx_char.nine);
    assign full = count_ff == FIFO_DEPTH;
    assign pop = rd_rxd && count_ff != 2'h0;
    assign push = rx_keep && (!full || pop);
    assign wi = count_ff - {1'b0, pop};

    // Control registers; software writes land on the writable bits only.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rs_ctl_ff <= RS_RST;
        end else if (wr_rs) begin
            // A write set of the single receive beats the hardware clear.
            rs_ctl_ff <= bus_i.wdata & RS_WMASK;
        end else if (sync_mode && master && sync_rx_done_i && !continuous_receive_enable) begin
            rs_ctl_ff[RS_SINGLE_RECEIVE_ENABLE] <= 1'b0;
        end
    end

    // Transmit control; bit 3 and the status bit are never stored.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ts_ctl_ff <= TS_RST;
        end else if (wr_ts) begin
            ts_ctl_ff <= bus_i.wdata & TS_WMASK;
        end
    end

    // Divisor and interrupt enable registers.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            baud_ff <= BAUD_RST;
            irq_en_ff <= IRQ_EN_RST;
        end else begin
            if (wr_baud) begin
                baud_ff <= bus_i.wdata;
            end
            if (wr_irq) begin
                irq_en_ff <= bus_i.wdata;
            end
        end
    end

    // Shift register status mirrors the transmit datapath.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_empty_ff <= 1'b1;
        end else begin
            tx_empty_ff <= !tx_shift_full_i;
        end
    end

    // Baud timer runs freely; a divisor write restarts it at once.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            brg_ff <= 8'h00;
            pre_ff <= 7'h00;
        end else if (!port_enable || wr_baud) begin
            brg_ff <= 8'h00;
            pre_ff <= 7'h00;
        end else if (brg_tick) begin
            brg_ff <= 8'h00;
            pre_ff <= (pre_ff >= mult - 7'h01) ? 7'h00 : pre_ff + 7'h01;
        end else begin
            brg_ff <= brg_ff + 8'h01;
        end
    end

    // Two-flop pin synchroniser; only the second flop feeds logic.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            s1_ff <= rx_i;
            s2_ff <= s1_ff;
            prev_ff <= s2_ff;
        end
    end

    // Character framing. The line is sampled once at bit centre, which
    // trades noise immunity for size.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= RX_IDLE;
            ph_ff <= 7'h00;
            bit_ff <= 4'h0;
            sh_ff <= 9'h000;
        end else if (!rx_en) begin
            state_ff <= RX_IDLE;
            ph_ff <= 7'h00;
        end else begin
            case (state_ff)
                RX_IDLE: begin
                    // An overrun blocks new characters until cleared.
                    if (prev_ff && !s2_ff && !overrun_error_flag_ff) begin
                        state_ff <= RX_START;
                        ph_ff <= 7'h00;
                    end
                end
                RX_START: begin
                    if (brg_tick) begin
                        if (ph_ff == (mult >> 1) - 7'h01) begin
                            // A high line at mid start is a glitch.
                            state_ff <= s2_ff ? RX_IDLE : RX_DATA;
                            ph_ff <= 7'h00;
                            bit_ff <= 4'h0;
                        end else begin
                            ph_ff <= ph_ff + 7'h01;
                        end
                    end
                end
                RX_DATA: begin
                    if (brg_tick) begin
                        if (ph_ff == mult - 7'h01) begin
                            sh_ff <= {s2_ff, sh_ff[8:1]};
                            bit_ff <= bit_ff + 4'h1;
                            ph_ff <= 7'h00;
                            if (bit_ff == (rx9 ? 4'h8 : 4'h7)) begin
                                state_ff <= RX_STOP;
                            end
                        end else begin
                            ph_ff <= ph_ff + 7'h01;
                        end
                    end
                end
                RX_STOP: begin
                    if (brg_tick) begin
                        if (rx_done) begin
                            state_ff <= RX_IDLE;
                            ph_ff <= 7'h00;
                        end else begin
                            ph_ff <= ph_ff + 7'h01;
                        end
                    end
                end
                default: begin
                    state_ff <= RX_IDLE;
                end
            endcase
        end
    end

    // Receive buffer: the top entry is index 0, a read shifts down.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_ff <= 2'h0;
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
        end else if (!port_enable) begin
            count_ff <= 2'h0;
        end else begin
            if (pop) begin
                mem_ff[0] <= mem_ff[1];
            end
            if (push) begin
                mem_ff[wi[0]] <= rx_char;
            end
            count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    // Overrun: set by a third character, cleared by dropping CONTINUOUS_RECEIVE_ENABLE.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            overrun_error_flag_ff <= 1'b0;
        end else if (!port_enable) begin
            overrun_error_flag_ff <= 1'b0;
        end else if (rx_keep && full && !pop) begin
            overrun_error_flag_ff <= 1'b1;
        end else if (!continuous_receive_enable) begin
            overrun_error_flag_ff <= 1'b0;
        end
    end

    // Status bits seen by software, taken from the top character.
    logic top_framing_error_flag, top_nine;
    assign top_framing_error_flag = count_ff != 2'h0 && mem_ff[0].framing_error_flag;
    assign top_nine = count_ff != 2'h0 && mem_ff[0].nine;

    // Read mux; unmapped indices read as zero.
    logic [7:0] nxt_rd_data;
    always_comb begin
        nxt_rd_data = 8'h00;
        if (bus_i.re) begin
            case (bus_i.addr)
                ADDR_RX_DATA: nxt_rd_data = mem_ff[0].data;
                ADDR_RX_STAT: begin
                    nxt_rd_data = rs_ctl_ff;
                    nxt_rd_data[RS_FRAMING_ERROR_FLAG] = top_framing_error_flag;
                    nxt_rd_data[RS_OVERRUN_ERROR_FLAG] = overrun_error_flag_ff;
                    nxt_rd_data[RS_RX_NINTH_DATA_BIT] = top_nine;
                end
                ADDR_TX_STAT: begin
                    nxt_rd_data = ts_ctl_ff;
                    nxt_rd_data[TS_TX_SHIFT_EMPTY] = tx_empty_ff;
                end
                ADDR_BAUD: nxt_rd_data = baud_ff;
                ADDR_IRQ_EN: nxt_rd_data = irq_en_ff;
                ADDR_IRQ_FLAG: nxt_rd_data[IRQ_RX_BIT] = count_ff != 2'h0;
                default: nxt_rd_data = 8'h00;
            endcase
        end
    end

    // Next values of the outputs.
    logic [1:0] nxt_count;
    uad_tx_ctl_t nxt_tx;
    assign nxt_count = (!port_enable) ? 2'h0 : count_ff + {1'b0, push} - {1'b0, pop};
    always_comb begin
        // A receive request in sync mode takes the line from the sender.
        nxt_tx.enable = port_enable && ts_ctl_ff[TS_TRANSMIT_ENABLE] && !(sync_mode && (single_receive_enable || continuous_receive_enable));
        nxt_tx.nine = ts_ctl_ff[TS_TX9];
        nxt_tx.ninth = ts_ctl_ff[TS_TX_NINTH_DATA_BIT];
        nxt_tx.master_clk = port_enable && sync_mode && master;
    end

    // Registered outputs.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_o <= 8'h00;
            rx_flag_o <= 1'b0;
            rx_irq_en_o <= 1'b0;
            tx_ctl_o <= '0;
            pin_serial_o <= 1'b0;
            sync_rx_en_o <= 1'b0;
            baud_tick_o <= 1'b0;
        end else begin
            rd_data_o <= nxt_rd_data;
            rx_flag_o <= nxt_count != 2'h0;
            rx_irq_en_o <= irq_en_ff[IRQ_RX_BIT];
            tx_ctl_o <= nxt_tx;
            pin_serial_o <= port_enable;
            // Continuous receive wins; single receive only as master.
            sync_rx_en_o <= port_enable && sync_mode && (continuous_receive_enable || (single_receive_enable && master));
            baud_tick_o <= port_enable && brg_tick && pre_ff == mult - 7'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    addr_filter_a: assert property (rx_done && addr_mode && !rx_char.nine && !pop |=> $stable(count_ff))
        else $error("address filter let a data character in");
    flag_raise_a: assert property (push |=> rx_flag_o)
        else $error("receive flag not raised after buffer load");
    ninth_one_a: assert property (push && addr_mode |-> rx_char.nine)
        else $error("buffered ninth bit clear under address detect");
    overrun_error_flag_clear_a: assert property (port_enable && !continuous_receive_enable |=> !overrun_error_flag_ff)
        else $error("overrun not cleared by receive disable");
    framing_error_flag_advance_a: assert property (port_enable && pop && !push && count_ff == 2'h2 |=> top_framing_error_flag == $past(mem_ff[1].framing_error_flag))
        else $error("framing flag did not follow next character");
    port_enable_reset_a: assert property (!port_enable |=> count_ff == 2'h0 && state_ff == RX_IDLE && !overrun_error_flag_ff)
        else $error("disabled port not held in reset");
    single_receive_enable_clear_a: assert property (sync_mode && master && sync_rx_done_i && !continuous_receive_enable && !wr_rs |=> !single_receive_enable)
        else $error("single receive not cleared on completion");
    tx_override_a: assert property (sync_mode && (single_receive_enable || continuous_receive_enable) |=> !tx_ctl_o.enable)
        else $error("transmit enabled while sync receive requested");
    bit3_zero_a: assert property (bus_i.re && bus_i.addr == ADDR_TX_STAT |=> !rd_data_o[3])
        else $error("transmit control bit 3 read nonzero");
    tx_shift_empty_follow_a: assert property (bus_i.re && bus_i.addr == ADDR_TX_STAT
        |=> rd_data_o[TS_TX_SHIFT_EMPTY] == !$past(tx_shift_full_i, 2))
        else $error("shift empty bit does not follow shift register");
    baud_restart_a: assert property (port_enable && wr_baud |=> brg_ff == 8'h00 && pre_ff == 7'h00)
        else $error("divisor write did not restart baud timer");
    overrun_hold_a: assert property (port_enable && overrun_error_flag_ff && !pop |=> count_ff == $past(count_ff))
        else $error("character accepted during overrun");
endmodule
`default_nettype wire

/* tb/uad_node.sv */
`timescale 1ns/1ps
`default_nettype none
module uad_node (
    input wire logic clk_i, // Clock that times each bit on the line.
    output logic line_o // Serial line toward the receiver, idle high.
);
    // The shared line is biased high, so it idles high between frames.
    initial begin
        line_o = 1'b1;
    end

    // Sends one frame, least significant bit first, then idles two bit times.
    // A low stop bit forges a framing fault; nothing else is ever sent wrong.
    task automatic send(input logic [8:0] data, input logic nine, input logic stop_bit, input int bit_clks);
        logic [10:0] bits;
        int n;
        bits = {stop_bit, data, 1'b0};
        n = 11;
        if (!nine) begin
            bits = {1'b1, stop_bit, data[7:0], 1'b0};
            n = 10;
        end
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            line_o <= bits[i];
            repeat (bit_clks - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        line_o <= 1'b1;
        repeat (2 * bit_clks) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import uad_pkg::*;
;
    logic clk_i = 1'b0; // System clock, 200 MHz.
    logic resetn_i = 1'b0; // Reset, active low.
    uad_bus_t bus = '0; // Register port request.
    logic [7:0] rd_data; // Read data from the block.
    logic rx_line; // Serial line from the remote node.
    logic tx_full = 1'b0; // Transmit shift register holds data.
    logic sync_done = 1'b0; // Synchronous reception finished.
    logic rx_flag; // Unread character present.
    logic rx_irq_en; // Receive interrupt enable copy.
    uad_tx_ctl_t tx_ctl; // Transmitter controls.
    logic pin_serial; // Pins owned by the serial port.
    logic sync_rx_en; // Synchronous receive requested.
    logic baud_tick; // Bit time pulse.
    int num_errors = 0; // Mismatches seen.
    int checks = 0; // Comparisons made.
    logic [7:0] d; // Scratch read value.
    int n; // Scratch cycle count.
    localparam int BIT = 16; // Clocks per bit at divisor 0 with high speed.

    // The clock toggles every 2.5 ns, half of its 5 ns period.
    always #2.5 clk_i = ~clk_i;

    uad_top i_dut (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .bus_i(bus),
        .rd_data_o(rd_data),
        .rx_i(rx_line),
        .tx_shift_full_i(tx_full),
        .sync_rx_done_i(sync_done),
        .rx_flag_o(rx_flag),
        .rx_irq_en_o(rx_irq_en),
        .tx_ctl_o(tx_ctl),
        .pin_serial_o(pin_serial),
        .sync_rx_en_o(sync_rx_en),
        .baud_tick_o(baud_tick)
    );

    uad_node i_node (
        .clk_i(clk_i),
        .line_o(rx_line)
    );

    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One write cycle; the strobe drops at the next edge.
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_i);
        bus.addr <= a;
        bus.wdata <= v;
        bus.we <= 1'b1;
        @(posedge clk_i);
        bus.we <= 1'b0;
    endtask

    // One read cycle; the data stand only in the cycle after the read edge.
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_i);
        bus.addr <= a;
        bus.re <= 1'b1;
        @(posedge clk_i);
        bus.re <= 1'b0;
        #1;
        v = rd_data;
    endtask

    // Reads a register and compares it.
    task automatic rdc(input string what, input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(what, v, exp);
    endtask

    // Lets registered outputs catch up with a register write.
    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    // Counts cycles up to the next bit time pulse, bounded against a hang.
    task automatic wait_tick(output int c);
        c = 0;
        do begin
            @(posedge clk_i);
            #1;
            c++;
        end while (baud_tick !== 1'b1 && c < 20000);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("Checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the expected run length.
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        summarize();
    end

    // Main sequence.
    initial begin
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        settle();
        chk("pin", {7'h0, pin_serial}, 8'h00);
        rdc("rs", ADDR_RX_STAT, 8'h00);
        rdc("ts", ADDR_TX_STAT, 8'h02);
        rdc("baud", ADDR_BAUD, 8'h00);
        wr(3'h7, 8'hff);
        rdc("unmapped", 3'h7, 8'h00);
        $display("Test reset values done");
        // High speed is chosen here since it keeps the rate error low.
        wr(ADDR_BAUD, 8'h00);
        wr(ADDR_TX_STAT, 8'hef);
        wr(ADDR_RX_STAT, 8'h80);
        settle();
        rdc("ts", ADDR_TX_STAT, 8'he7);
        chk("tx_ctl", {4'h0, tx_ctl}, 8'h0e);
        @(posedge clk_i);
        tx_full <= 1'b1;
        rdc("ts_full", ADDR_TX_STAT, 8'he5);
        @(posedge clk_i);
        tx_full <= 1'b0;
        wr(ADDR_TX_STAT, 8'h04);
        $display("Test transmit controls done");
        wr(ADDR_IRQ_EN, 8'h20);
        wr(ADDR_RX_STAT, 8'hc0);
        wr(ADDR_RX_STAT, 8'hc8);
        wr(ADDR_RX_STAT, 8'hd8);
        settle();
        chk("pin", {7'h0, pin_serial}, 8'h01);
        chk("irq_en", {7'h0, rx_irq_en}, 8'h01);
        i_node.send(9'h055, 1'b1, 1'b1, BIT);
        chk("flag_drop", {7'h0, rx_flag}, 8'h00);
        i_node.send(9'h1a3, 1'b1, 1'b1, BIT);
        chk("flag_addr", {7'h0, rx_flag}, 8'h01);
        rd(ADDR_IRQ_FLAG, d);
        chk("irq_flag", d & 8'h20, 8'h20);
        rdc("rs_addr", ADDR_RX_STAT, 8'hd9);
        rdc("data_addr", ADDR_RX_DATA, 8'ha3);
        // Our address matched, so every following character is wanted.
        wr(ADDR_RX_STAT, 8'hd0);
        i_node.send(9'h03c, 1'b1, 1'b1, BIT);
        rdc("rs_plain", ADDR_RX_STAT, 8'hd0);
        rdc("data_plain", ADDR_RX_DATA, 8'h3c);
        $display("Test address detect done");
        i_node.send(9'h011, 1'b1, 1'b0, BIT);
        i_node.send(9'h122, 1'b1, 1'b1, BIT);
        i_node.send(9'h033, 1'b1, 1'b1, BIT);
        rdc("rs_over", ADDR_RX_STAT, 8'hd6);
        rdc("data_c1", ADDR_RX_DATA, 8'h11);
        rdc("rs_next", ADDR_RX_STAT, 8'hd3);
        rdc("data_c2", ADDR_RX_DATA, 8'h22);
        wr(ADDR_RX_STAT, 8'hc0);
        rdc("rs_clr", ADDR_RX_STAT, 8'hc0);
        wr(ADDR_RX_STAT, 8'hd0);
        i_node.send(9'h044, 1'b1, 1'b1, BIT);
        rdc("data_c4", ADDR_RX_DATA, 8'h44);
        $display("Test framing and overrun done");
        wr(ADDR_RX_STAT, 8'h98);
        i_node.send(9'h081, 1'b0, 1'b1, BIT);
        rdc("rs_8bit", ADDR_RX_STAT, 8'h98);
        rdc("data_8bit", ADDR_RX_DATA, 8'h81);
        i_node.send(9'h05a, 1'b0, 1'b1, BIT);
        wr(ADDR_RX_STAT, 8'h00);
        settle();
        chk("flag_off", {7'h0, rx_flag}, 8'h00);
        chk("pin_off", {7'h0, pin_serial}, 8'h00);
        $display("Test eight bit and disable done");
        wr(ADDR_TX_STAT, 8'hb0);
        wr(ADDR_RX_STAT, 8'h90);
        settle();
        chk("sync_continuous_receive_enable", {7'h0, sync_rx_en}, 8'h01);
        chk("master_clk", {7'h0, tx_ctl.master_clk}, 8'h01);
        chk("tx_override", {7'h0, tx_ctl.enable}, 8'h00);
        wr(ADDR_TX_STAT, 8'h90);
        wr(ADDR_RX_STAT, 8'ha0);
        settle();
        chk("sync_single_receive_enable", {7'h0, sync_rx_en}, 8'h01);
        @(posedge clk_i);
        sync_done <= 1'b1;
        @(posedge clk_i);
        sync_done <= 1'b0;
        settle();
        rdc("rs_single_receive_enable", ADDR_RX_STAT, 8'h80);
        wr(ADDR_TX_STAT, 8'h10);
        wr(ADDR_RX_STAT, 8'ha0);
        settle();
        chk("sync_slave", {7'h0, sync_rx_en}, 8'h00);
        chk("slave_clk", {7'h0, tx_ctl.master_clk}, 8'h00);
        $display("Test synchronous controls done");
        wr(ADDR_BAUD, 8'h02);
        wr(ADDR_TX_STAT, 8'h14);
        wait_tick(n);
        wait_tick(n);
        chk("gap_sync", 8'(n), 8'h0c);
        wr(ADDR_TX_STAT, 8'h00);
        wr(ADDR_BAUD, 8'hff);
        repeat (100) @(posedge clk_i);
        wr(ADDR_BAUD, 8'h02);
        wait_tick(n);
        chk("restart", 8'(n), 8'hc0);
        wait_tick(n);
        chk("gap_low", 8'(n), 8'hc0);
        wr(ADDR_TX_STAT, 8'h04);
        wait_tick(n);
        wait_tick(n);
        chk("gap_high", 8'(n), 8'h30);
        $display("Test baud generator done");
        summarize();
    end
endmodule
`default_nettype wire
